/* File: csg_clock_generator.sv */
// Purpose: Clock source generator: source choice, dividers, reference, monitor, lock events
// Assumes: All clocks are one-cycle enable ticks synchronous to pclk
// Notes:   Analog loops live outside; they take ref_div_tick and return their ticks
//          Reference divider retunes at once; only the system clock path waits a boundary
// Function
// [R1] Source code 00 picks loop output, 01 internal reference, 10 external reference.
// [R2] Reserved source code 11 acts exactly like 00, the loop output.
// [R3] Reference divider codes divide by 1,2,4,8,16 and 128 for 111; reset 000.
// [R4] Software keeps the divided reference at 31.25-39.0625 kHz for the frequency loop.
// [R5] Software keeps the divided reference at 1-2 MHz for the phase loop.
// [R6] Reference select bit 2 picks internal reference when set, external when clear.
// [R7] Enable bit 1 drives the internal reference clock output; cleared holds it idle.
// [R8] Stop enable bit 0 keeps internal reference alive in stop under conditions.
// [R9] Selected source passes an output divider of 1, 2, 4 or 8.
// [R10] Debug clock is the controlled oscillator divided by two in loop modes.
// [R11] Software uses phase loop engaged external mode for 48 MHz USB clock.
// [R12] Nine operating modes are supported and reported.
// [R13] Phase loop lock detector can raise an interrupt.
// [R14] External reference is monitored; failure requests a reset.
// [R15] Nine trim bits adjust the internal reference period.
// [R16] The block controls the external oscillator enable.
// [R17] Either reference may serve the frequency loop.
// [R18] Output divider codes 00-11 divide by 1,2,4,8; reset code 01.
// [R19] Source and divider changes switch only at period boundaries, without runts.
`timescale 1ns/1ns
`default_nettype none
module csg_clock_generator
	import csg_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire csg_apb_req_s apb_req,
	output csg_apb_rsp_s      apb_rsp,
	input  wire logic         ext_ref_tick,
	input  wire logic         dco_tick,
	input  wire logic         vco_tick,
	input  wire logic         pll_lock,
	input  wire logic         stop_req,
	output logic              generator_output_clock,
	output logic              int_ref_clock_out,
	output logic              ref_div_tick,
	output logic              debug_clock_out,
	output logic              osc_enable,
	output logic              loop_enable,
	output logic [8:0]        trim_value,
	output logic              reset_req,
	output logic              irq
);

	typedef struct packed {
		logic [7:0]    ctrl1;
		logic [7:0]    ctrl2;
		logic [8:0]    trim;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] mask;
		logic [1:0]    src_act;
		logic [1:0]    odiv_act;
		logic [9:0]    iref_cnt;
		logic          iref_tick;
		logic          irclk;
		logic          dbg;
		logic          lock_s;
		logic          was_int;
		logic [11:0]   mon_cnt;
		logic          rst_req;
		logic          osc_en;
		logic          loop_en;
		logic          irq;
		csg_mode_e     mode;
		csg_apb_rsp_s  rsp;
	} csg_state_s;

	csg_state_s st_q;
	csg_state_s st_d;

	// Decoded control fields
	logic [1:0] src_sel;
	logic [2:0] ref_divider_code;
	logic       ref_sel;
	logic       iren;
	logic       isten;
	logic [1:0] odiv_code;
	logic       pll_sel;
	logic       low_pow;
	logic       osc_bit;
	logic       mon_bit;

	assign src_sel   = st_q.ctrl1[C1_SRC_POS +: 2];
	assign ref_divider_code = st_q.ctrl1[C1_REF_DIVIDER_POS +: 3];
	assign ref_sel   = st_q.ctrl1[C1_RSEL_POS];
	assign iren      = st_q.ctrl1[C1_IREN_POS];
	assign isten     = st_q.ctrl1[C1_STEN_POS];
	assign odiv_code = st_q.ctrl2[C2_ODIV_POS +: 2];
	assign pll_sel   = st_q.ctrl2[C2_PLL_POS];
	assign low_pow   = st_q.ctrl2[C2_LP_POS];
	assign osc_bit   = st_q.ctrl2[C2_OSC_POS];
	assign mon_bit   = st_q.ctrl2[C2_MON_POS];

	// Reference tick for the loops: internal or external
	logic loop_ref_tick;
	assign loop_ref_tick = ref_sel ? st_q.iref_tick : ext_ref_tick; // [R6] [R17]

	// The reference ratio switches at once; a retune may give one short reference
	// period, which the loops ride out, unlike the system clock path below
	logic ref_divider_pulse;
	csg_pow2_div #(
		.CODE_W (3)
	) u_ref_div (
		.pclk       (pclk),
		.presetn    (presetn),
		.tick_i     (loop_ref_tick),
		.code_i     (ref_divider_code), // [R3]
		.pulse_o    (ref_divider_pulse),
		.at_start_o ()
	);

	// Loop output is the frequency or phase loop tick
	logic loop_tick;
	assign loop_tick = pll_sel ? vco_tick : dco_tick;

	// Tick of the source that the output divider currently follows
	// The mux follows src_act, not the register field, so a switch waits for a boundary
	logic src_tick;
	always_comb begin
		case (st_q.src_act)
			SRC_IREF: src_tick = st_q.iref_tick; // [R1]
			SRC_EREF: src_tick = ext_ref_tick;   // [R1]
			default:  src_tick = loop_tick;      // [R1] [R2]
		endcase
	end

	// Stop gates source ticks ahead of the divider so no pulse leaves after the first stop cycle;
	// the count is kept, so the period in progress resumes where it paused
	logic odiv_pulse;
	logic odiv_start;
	csg_pow2_div #(
		.CODE_W (2)
	) u_out_div (
		.pclk       (pclk),
		.presetn    (presetn),
		.tick_i     (src_tick & !stop_req),
		.code_i     (st_q.odiv_act), // [R9] [R18]
		.pulse_o    (odiv_pulse),
		.at_start_o (odiv_start)
	);

	// Mode from the control fields; reserved source code counts as loop output
	// Stop outranks every field; whether the mode just before stop was an internal reference mode survives in was_int
	csg_mode_e mode_c;
	always_comb begin
		if (stop_req) begin
			mode_c = mode_stop;
		end else begin
			case (src_sel)
				SRC_IREF: mode_c = low_pow ? low_power_bypass_internal
				                           : loop_bypassed_internal;
				SRC_EREF: begin
					if (low_pow) begin
						mode_c = low_power_bypass_external;
					end else begin
						mode_c = pll_sel ? phase_loop_bypassed_external
						                 : loop_bypassed_external;
					end
				end
				default: begin
					if (pll_sel) begin
						mode_c = phase_loop_engaged_external;
					end else begin
						mode_c = ref_sel ? loop_engaged_internal : loop_engaged_external;
					end
				end
			endcase
		end
	end // [R12] [R2]

	// APB decode
	// Unmapped offsets answer with an error and read 0; data sits in the low bits
	logic       acc;
	logic       wr_en;
	logic       mapped;
	logic [31:0] rdata;
	assign acc   = apb_req.psel && apb_req.penable;
	assign wr_en = acc && apb_req.pwrite && st_q.rsp.pready;

	always_comb begin
		mapped = 1'b1;
		rdata  = 32'h0000_0000;
		case (apb_req.paddr)
			OFS_CTRL1:  rdata[7:0]      = st_q.ctrl1;
			OFS_CTRL2:  rdata[7:0]      = st_q.ctrl2;
			OFS_TRIM:   rdata[8:0]      = st_q.trim;
			OFS_STATUS: rdata[ST_W-1:0] = st_q.status;
			OFS_MASK:   rdata[ST_W-1:0] = st_q.mask;
			OFS_STATE:  rdata[5:0]      = {st_q.iref_tick | st_q.irclk, st_q.lock_s, st_q.mode};
			default:    mapped          = 1'b0;
		endcase
	end

	// Internal reference may run in stop only when allowed
	// Halting it otherwise in stop saves its running current
	logic iref_run;
	assign iref_run = !stop_req || (isten && (iren || st_q.was_int)); // [R8]

	logic lock_evt;
	logic loss_evt;
	logic [ST_W-1:0] evt;
	logic [ST_W-1:0] clr;
	logic [9:0]      iref_limit;

	// Gaining and losing lock are both events; software reads the level in state
	// A dead reference fires once per silent window and the count restarts,
	// so software sees repeated reset requests until the clock returns
	assign lock_evt   = (pll_lock != st_q.lock_s);
	assign loss_evt   = osc_bit && mon_bit && !stop_req && !ext_ref_tick
	                    && (st_q.mon_cnt == 12'(MON_TIMEOUT_CYC - 1));
	assign iref_limit = 10'(IREF_BASE_CYC) + {1'b0, st_q.trim};

	always_comb begin
		evt              = '0;
		evt[ST_LOCK_POS] = lock_evt;
		evt[ST_LOSS_POS] = loss_evt;
		clr              = '0;
		if (wr_en && apb_req.paddr == OFS_STATUS) begin
			clr = apb_req.pwdata[ST_W-1:0];
		end
	end

	// Next state of the whole block
	always_comb begin
		st_d = st_q;

		// Bus answer: one wait state, then complete
		// Read data is cleared outside the answer cycle so no stale word lingers
		st_d.rsp.pready = acc && !st_q.rsp.pready;
		if (acc && !st_q.rsp.pready) begin
			st_d.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rdata;
			st_d.rsp.pslverr = !mapped;
		end else begin
			st_d.rsp.prdata  = 32'h0000_0000;
			st_d.rsp.pslverr = 1'b0;
		end

		// Register writes land at the completing edge
		// Status is not written here: a write of ones clears it through clr
		if (wr_en) begin
			case (apb_req.paddr)
				OFS_CTRL1: st_d.ctrl1 = apb_req.pwdata[7:0];
				OFS_CTRL2: st_d.ctrl2 = apb_req.pwdata[7:0];
				OFS_TRIM:  st_d.trim  = apb_req.pwdata[8:0]; // [R15]
				OFS_MASK:  st_d.mask  = apb_req.pwdata[ST_W-1:0];
				default:   st_d.ctrl1 = st_q.ctrl1;
			endcase
		end

		// Sticky events; a set in the same cycle as a clear wins
		// Losing an event would hide a lock change or a clock loss from software
		st_d.status = (st_q.status & ~clr) | evt; // [R13] [R14]

		// Output selection follows software only between periods
		if (odiv_start || odiv_pulse) begin
			st_d.src_act  = src_sel;   // [R19]
			st_d.odiv_act = odiv_code; // [R19]
		end

		// Trimmed internal reference: longer trim gives a longer period
		// The count restarts whenever it halts, so it never resumes mid period
		st_d.iref_tick = 1'b0;
		if (!iref_run) begin
			st_d.iref_cnt = 10'h000;
		end else if (st_q.iref_cnt >= iref_limit - 10'h001) begin
			st_d.iref_cnt  = 10'h000;
			st_d.iref_tick = 1'b1; // [R15]
		end else begin
			st_d.iref_cnt = st_q.iref_cnt + 10'h001;
		end
		st_d.irclk = st_d.iref_tick && iren; // [R7]

		// Remember whether an internal reference mode ran before stop
		if (!stop_req) begin
			st_d.was_int = (mode_c == loop_engaged_internal)
			            || (mode_c == loop_bypassed_internal)
			            || (mode_c == low_power_bypass_internal); // [R8]
		end

		// Debug clock halves the controlled oscillator while the loop is alive
		// It freezes rather than resets, so the debug side sees no extra edge
		if (dco_tick && st_q.loop_en) begin
			st_d.dbg = !st_q.dbg; // [R10]
		end

		// Lock detector edge capture
		// One flop of history; pll_lock is taken as synchronous to pclk
		st_d.lock_s = pll_lock; // [R13]

		// Clock monitor counts pclk cycles between external ticks
		if (!(osc_bit && mon_bit) || stop_req || ext_ref_tick || loss_evt) begin
			st_d.mon_cnt = 12'h000;
		end else begin
			st_d.mon_cnt = st_q.mon_cnt + 12'h001;
		end
		st_d.rst_req = loss_evt; // [R14]

		// Oscillator runs when asked and either not stopped or feeding the output
		// Keeping a feeding oscillator up in stop avoids its start-up delay on wake
		st_d.osc_en = osc_bit && (!stop_req || src_sel == SRC_EREF); // [R16]

		// Loops idle in low power bypass and in stop
		st_d.loop_en = !stop_req && !(low_pow && (src_sel == SRC_IREF || src_sel == SRC_EREF));

		st_d.mode = mode_c;
		// Registered level of masked status, so the interrupt pin never glitches
		st_d.irq  = |(st_d.status & st_q.mask);
	end

	// State register
	// Reset loads the register defaults; the active ratio starts at the reset code too
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q          <= '0;
			st_q.ctrl1    <= CTRL1_RST; // [R3]
			st_q.ctrl2    <= CTRL2_RST; // [R18]
			st_q.trim     <= TRIM_RST;
			st_q.odiv_act <= CTRL2_RST[C2_ODIV_POS +: 2];
			st_q.mode     <= loop_engaged_internal;
			st_q.loop_en  <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flip-flops
	assign apb_rsp                = st_q.rsp;
	assign generator_output_clock = odiv_pulse;
	assign int_ref_clock_out      = st_q.irclk;
	assign ref_div_tick           = ref_divider_pulse;
	assign debug_clock_out        = st_q.dbg;
	assign osc_enable             = st_q.osc_en;
	assign loop_enable            = st_q.loop_en;
	assign trim_value             = st_q.trim;
	assign reset_req              = st_q.rst_req;
	assign irq                    = st_q.irq;

endmodule
`default_nettype wire

/* File: csg_clock_generator_sva.sv */
// Purpose: Port-level assertions for the clock source generator
// Assumes: One pclk domain, asynchronous active-low presetn
// Notes:   Loss check leaves a few cycles of slack for register stages
`timescale 1ns/1ns
`default_nettype none
module csg_clock_generator_chk
	import csg_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire csg_apb_req_s apb_req,
	input  wire csg_apb_rsp_s apb_rsp,
	input  wire logic         ext_ref_tick,
	input  wire logic         dco_tick,
	input  wire logic         stop_req,
	input  wire logic         generator_output_clock,
	input  wire logic         int_ref_clock_out,
	input  wire logic         debug_clock_out,
	input  wire logic         loop_enable,
	input  wire logic         reset_req
);
	localparam int unsigned LOSS_MIN = MON_TIMEOUT_CYC - 8;
	int unsigned gap_d;
	int unsigned gap_q;
	// Cycles since the last external tick; saturates so it never wraps
	always_comb begin
		gap_d = gap_q;
		if (ext_ref_tick)
			gap_d = 0;
		else if (gap_q < 32'd100000)
			gap_d = gap_q + 1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gap_q <= 0;
		else
			gap_q <= gap_d;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_apb_one_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
		else $error("pready late");
	a_pready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready longer than one cycle");
	a_slverr_map: assert property (apb_rsp.pready && apb_req.paddr[1:0] == 2'h0
		|-> apb_rsp.pslverr == (apb_req.paddr > OFS_STATE)) else $error("pslverr wrong");
	a_stop_quiet: assert property (stop_req [*2] |-> !generator_output_clock)
		else $error("output clock during stop");
	a_debug_toggle: assert property (dco_tick && loop_enable && !stop_req
		|=> debug_clock_out != $past(debug_clock_out)) else $error("debug clock missed");
	a_debug_hold: assert property (!dco_tick |=> $stable(debug_clock_out))
		else $error("debug clock moved without tick");
	a_loss_single: assert property (reset_req |=> !reset_req)
		else $error("reset request too long");
	a_loss_gap: assert property (reset_req |-> gap_q >= LOSS_MIN)
		else $error("reset request without clock gap");
	a_iref_single: assert property (int_ref_clock_out |=> !int_ref_clock_out)
		else $error("internal reference pulse too long");
	c_slverr: cover property (apb_rsp.pready && apb_rsp.pslverr);
	c_loss: cover property (reset_req);
	c_stop: cover property (stop_req && int_ref_clock_out);
endmodule
bind csg_clock_generator csg_clock_generator_chk i_chk (.pclk(pclk), .presetn(presetn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .ext_ref_tick(ext_ref_tick), .dco_tick(dco_tick),
	.stop_req(stop_req), .generator_output_clock(generator_output_clock),
	.int_ref_clock_out(int_ref_clock_out), .debug_clock_out(debug_clock_out),
	.loop_enable(loop_enable), .reset_req(reset_req));
`default_nettype wire

/* File: csg_pkg.sv */
// Purpose: Shared constants, types and register map of the clock source generator
// Assumes: 32-bit APB, pclk at 20 MHz
// Notes:   Offsets are byte addresses; every register is one aligned word
package csg_pkg;

	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS   = 50;
	localparam int unsigned MON_TIMEOUT_NS  = 100000;   // Longest gap between reference ticks
	localparam int unsigned MON_TIMEOUT_CYC = MON_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int unsigned IREF_BASE_CYC   = 369;      // Period with trim at zero

	// Register offsets
	localparam logic [7:0] OFS_CTRL1  = 8'h00;
	localparam logic [7:0] OFS_CTRL2  = 8'h04;
	localparam logic [7:0] OFS_TRIM   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_MASK   = 8'h10;
	localparam logic [7:0] OFS_STATE  = 8'h14;

	// Reset values
	localparam logic [7:0] CTRL1_RST = 8'h04;
	localparam logic [7:0] CTRL2_RST = 8'h40;
	localparam logic [8:0] TRIM_RST  = 9'h100;

	// Field positions of clock_control_one
	localparam int unsigned C1_SRC_POS  = 6;
	localparam int unsigned C1_REF_DIVIDER_POS = 3;
	localparam int unsigned C1_RSEL_POS = 2;
	localparam int unsigned C1_IREN_POS = 1;
	localparam int unsigned C1_STEN_POS = 0;

	// Field positions of the second control register
	localparam int unsigned C2_ODIV_POS = 6;
	localparam int unsigned C2_PLL_POS  = 5;
	localparam int unsigned C2_LP_POS   = 4;
	localparam int unsigned C2_OSC_POS  = 3;
	localparam int unsigned C2_MON_POS  = 2;

	// Status and mask bits
	localparam int unsigned ST_LOCK_POS = 0;
	localparam int unsigned ST_LOSS_POS = 1;
	localparam int unsigned ST_W        = 2;

	// Source select codes
	localparam logic [1:0] SRC_LOOP = 2'h0;
	localparam logic [1:0] SRC_IREF = 2'h1;
	localparam logic [1:0] SRC_EREF = 2'h2;
	localparam logic [1:0] SRC_RSVD = 2'h3;

	typedef enum logic [3:0] {
		loop_engaged_internal,
		loop_engaged_external,
		loop_bypassed_internal,
		loop_bypassed_external,
		phase_loop_engaged_external,
		phase_loop_bypassed_external,
		low_power_bypass_internal,
		low_power_bypass_external,
		mode_stop
	} csg_mode_e;

	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} csg_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} csg_apb_rsp_s;

endpackage

/* File: csg_pow2_div.sv */
// Purpose: Divides a stream of enable ticks by two to the power of a code
// Assumes: tick_i is a one-cycle enable in the pclk domain
// Notes:   at_start_o marks a period boundary where the ratio may change safely
`timescale 1ns/1ns
`default_nettype none
module csg_pow2_div
	import csg_pkg::*;
#(
	parameter int unsigned CODE_W = 3
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              tick_i,
	input  wire logic [CODE_W-1:0] code_i,
	output logic                   pulse_o,
	output logic                   at_start_o
);

	typedef struct packed {
		logic [7:0] cnt;
		logic       pulse;
	} csg_div_s;

	csg_div_s   st_q;
	csg_div_s   st_d;
	logic [7:0] limit;

	// Ratio minus one; codes above seven never reach here
	assign limit = 8'((9'h1 << code_i) - 9'h1);

	// Count input ticks, emit one pulse per full period
	always_comb begin
		st_d       = st_q;
		st_d.pulse = 1'b0;
		if (tick_i) begin
			if (st_q.cnt >= limit) begin
				st_d.cnt   = 8'h00;
				st_d.pulse = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pulse_o    = st_q.pulse;
	assign at_start_o = (st_q.cnt == 8'h00) && !tick_i;

endmodule
`default_nettype wire

/* File: tb_csg_clock_generator.sv */
// Purpose: Self-checking bench for the clock source generator
// Assumes: Free-running source ticks; counts taken over windows that fit their periods
// Notes:   Trim is set to 0 so the internal reference period is IREF_BASE_CYC
`timescale 1ns/1ns
`default_nettype none
module tb_csg_clock_generator;
	import csg_pkg::*;
	logic         pclk, presetn, ext_ref_tick, dco_tick, vco_tick, pll_lock, stop_req, ext_on;
	csg_apb_req_s apb_req;
	csg_apb_rsp_s apb_rsp;
	logic         gen_clk, iref_clk, refdiv, dbg, osc_en, loop_en, rst_req, irq, slv;
	logic [8:0]   trim;
	logic [31:0]  cyc, rd;
	logic [31:0]  cnt[4];
	logic [31:0]  d[4];
	int           err_total, total_checks;
	localparam int P4 = 4 * IREF_BASE_CYC; // Whole periods of every source except vco_tick
	csg_clock_generator i_csg_clock_generator (.pclk(pclk), .presetn(presetn),
		.apb_req(apb_req), .apb_rsp(apb_rsp), .ext_ref_tick(ext_ref_tick),
		.dco_tick(dco_tick), .vco_tick(vco_tick), .pll_lock(pll_lock), .stop_req(stop_req),
		.generator_output_clock(gen_clk), .int_ref_clock_out(iref_clk),
		.ref_div_tick(refdiv), .debug_clock_out(dbg), .osc_enable(osc_en),
		.loop_enable(loop_en), .trim_value(trim), .reset_req(rst_req), .irq(irq));
	always #25 pclk = ~pclk;
	// Source ticks and pulse counters; ticks are periodic so window counts are exact
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		dco_tick <= cyc[0];
		vco_tick <= (cyc[2:0] == 3'h7);
		ext_ref_tick <= ext_on && (cyc[1:0] == 2'h3);
		cnt[0] <= cnt[0] + {31'h0, gen_clk};
		cnt[1] <= cnt[1] + {31'h0, iref_clk};
		cnt[2] <= cnt[2] + {31'h0, refdiv};
		cnt[3] <= cnt[3] + {31'h0, rst_req};
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		slv = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		check(32'(n), 32'h2); // One wait state: pready in the second access cycle
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask
	// Pulse counts over n cycles after a settling gap
	task automatic span(input int settle, input int n);
		logic [31:0] s[4];
		repeat (settle) @(posedge pclk);
		s = cnt;
		repeat (n) @(posedge pclk);
		foreach (d[i]) d[i] = cnt[i] - s[i];
	endtask
	task automatic t_reset();
		apb(1'b0, OFS_CTRL1, 0); check(rd, 32'h04);
		apb(1'b0, OFS_CTRL2, 0); check(rd, 32'h40);
		apb(1'b0, OFS_TRIM, 0); check(rd, 32'h100);
		apb(1'b0, OFS_STATE, 0); check(rd[3:0], 4'h0);
		apb(1'b0, 8'h40, 0);
		check(rd, 32'h0);
		check({31'h0, slv}, 32'h1);
		wr(OFS_TRIM, 0);
		@(posedge pclk);
		check(trim, 9'h0);
	endtask
	task automatic t_source();
		logic [31:0] exp[4] = '{P4 / 2, 4, P4 / 4, P4 / 2};
		wr(OFS_CTRL2, 32'h08);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CTRL1, c << 6);
			span(8, P4); check(d[0], exp[c]);
		end
	endtask
	task automatic t_outdiv();
		logic b;
		wr(OFS_CTRL1, 0);
		// Two edges hold exactly one oscillator tick, so the debug clock flips once
		b = dbg;
		repeat (2) @(posedge pclk);
		check({31'h0, dbg}, {31'h0, !b});
		for (int k = 0; k < 4; k++) begin
			wr(OFS_CTRL2, (k << 6) | 8);
			span(40, 128); check(d[0], 64 >> k);
		end
	endtask
	task automatic t_refdiv();
		int codes[6] = '{0, 1, 2, 3, 4, 7};
		foreach (codes[i]) begin
			wr(OFS_CTRL1, codes[i] << 3);
			span(520, 512); check(d[2], codes[i] == 7 ? 1 : 128 >> codes[i]);
		end
		wr(OFS_CTRL1, 32'h04);
		span(8, P4); check(d[2], 4);
	endtask
	task automatic t_intref();
		wr(OFS_CTRL1, 32'h02); span(8, P4); check(d[1], 4);
		wr(OFS_CTRL1, 32'h00); span(8, P4); check(d[1], 0);
		wr(OFS_CTRL1, 32'h03); stop_req <= 1'b1;
		span(8, P4); check(d[1], 4);
		check({31'h0, loop_en}, 32'h0);
		apb(1'b0, OFS_STATE, 0); check(rd[3:0], 4'h8);
		stop_req <= 1'b0; wr(OFS_CTRL1, 32'h02); stop_req <= 1'b1;
		span(8, P4); check(d[1], 0);
		stop_req <= 1'b0;
		// Internal mode before stop keeps the reference alive with its output gated off
		wr(OFS_CTRL1, 32'h45);
		repeat (2) @(posedge pclk);
		stop_req <= 1'b1;
		span(8, P4);
		check(d[2], 4);
		check(d[1], 0);
		stop_req <= 1'b0;
	endtask
	task automatic t_irq();
		wr(OFS_MASK, 1); pll_lock <= 1'b1; span(4, 1); check(irq, 1'b1);
		apb(1'b0, OFS_STATUS, 0); check(rd, 32'h1);
		wr(OFS_STATUS, 1); span(2, 1); check(irq, 1'b0);
		wr(OFS_MASK, 0); pll_lock <= 1'b0; span(4, 1); check(irq, 1'b0);
		apb(1'b0, OFS_STATUS, 0); check(rd, 32'h1);
		wr(OFS_STATUS, 1);
	endtask
	// Every running mode through the state register, with the loop power that goes with it
	// Entry 1 divides the 5 MHz external reference by 128 for the frequency loop
	// Entry 4 divides it by 4 to 1.25 MHz for the phase loop, engaged for USB
	task automatic t_modes();
		logic [7:0] c1[8] = '{8'h04, 8'h38, 8'h44, 8'h80, 8'h10, 8'h90, 8'h44, 8'h80};
		logic [7:0] c2[8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h28, 8'h28, 8'h18, 8'h18};
		for (int m = 0; m < 8; m++) begin
			wr(OFS_CTRL2, {24'h0, c2[m]});
			wr(OFS_CTRL1, {24'h0, c1[m]});
			apb(1'b0, OFS_STATE, 0);
			check({28'h0, rd[3:0]}, 32'(m));
			check({31'h0, loop_en}, (m < 6) ? 32'h1 : 32'h0);
		end
		wr(OFS_CTRL2, 32'h28);
		wr(OFS_CTRL1, 32'h10);
		span(40, 512);
		check(d[0], 64);
		check(d[2], 32);
	endtask
	task automatic t_loss();
		wr(OFS_CTRL2, 32'h0c); ext_on <= 1'b0;
		span(1, MON_TIMEOUT_CYC + 100); check(d[3], 1);
		apb(1'b0, OFS_STATUS, 0); check(rd, 32'h2);
		check({31'h0, osc_en}, 32'h1);
		ext_on <= 1'b1; wr(OFS_STATUS, 2);
		wr(OFS_CTRL2, 32'h40);
		repeat (2) @(posedge pclk);
		check({31'h0, osc_en}, 32'h0);
	endtask
	// Watchdog sized well above the roughly 24650 cycles of the sequence
	initial begin
		repeat (60000) @(posedge pclk);
		err_total++;
		report_and_stop();
	end
	initial begin
		pclk = 0; presetn = 0; apb_req = '0; stop_req = 0; pll_lock = 0; ext_on = 1;
		cyc = 0; dco_tick = 0; vco_tick = 0; ext_ref_tick = 0; cnt = '{4{32'h0}};
		err_total = 0; total_checks = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset(); t_source(); t_outdiv(); t_refdiv(); t_intref(); t_irq(); t_modes(); t_loss();
		report_and_stop();
	end
endmodule
`default_nettype wire
